/* pbs_datapath.sv */
// Purpose: packed byte pack and quad byte subtract execution with issue checks
// Assumes: decoder and register file on the same clock; register reads valid with issue
// Notes: one registered stage; subtract-absolute-accumulate only gets operand checks
// Contract
// - pack takes bytes 0 and 2 of each source, first source low
// - quad subtract: byte pairs 0,1 to destination A, pairs 2,3 to B
// - bytes unsigned, difference written sign-extended into sixteen bits
// - quad subtract sources only data_pair_low or data_pair_high
// - first window offset from two low bits of first_align_index
// - second window offset from two low bits of second_align_index
// - forward view high register bytes 7..4, offset picks start byte
// - reverse option takes low-order bytes from high register
// - reverse view low register bytes 7..4, same offset choice
// - suppress misalign fault of parallel 32-bit loads while issued
// - all three operations must be 32-bit instruction words
// - only allowed 16-bit companions may share the bundle
// - subtract-absolute-accumulate sources only the two pairs
`default_nettype none
module pbs_datapath (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // issue from decoder
    input wire pbs_pkg::pbs_issue_t issue,
    input wire pbs_pkg::pbs_slot_t slotA,
    input wire pbs_pkg::pbs_slot_t slotB,
    // register file read and index registers
    input wire pbs_pkg::pbs_regs_t regs,
    input wire logic [pbs_pkg::OFFSET_W-1:0] firstAlignIndex,
    input wire logic [pbs_pkg::OFFSET_W-1:0] secondAlignIndex,
    // register file writes
    output pbs_pkg::pbs_write_t writeA,
    output pbs_pkg::pbs_write_t writeB,
    // status towards core
    output logic illegalIssue,
    output logic flagWrite,
    output logic misalignSuppress,
    // operands for the accumulate unit
    output logic saaAccept,
    output logic [pbs_pkg::DATA_W-1:0] saaBytesA,
    output logic [pbs_pkg::DATA_W-1:0] saaBytesB
);
    import pbs_pkg::*;

    logic isPack;
    logic isQsub;
    logic isSaa;
    logic isByteOp;
    logic pairOkA;
    logic pairOkB;
    logic slotOkA;
    logic slotOkB;
    logic encodingOk;
    logic accept;
    logic [DATA_W-1:0] packWord;
    logic [DATA_W-1:0] windowA;
    logic [DATA_W-1:0] windowB;
    logic [DATA_W-1:0] diffLow;
    logic [DATA_W-1:0] diffHigh;
    logic [LANES-1:0][HALF_W-1:0] diff;
    pbs_write_t writeA_d;
    pbs_write_t writeB_d;
    pbs_write_t writeA_q;
    pbs_write_t writeB_q;
    logic illegal_q;
    logic flag_q;
    logic saaAccept_q;
    logic [DATA_W-1:0] saaA_q;
    logic [DATA_W-1:0] saaB_q;

    // decode
    assign isPack = issue.valid && (issue.op == PBS_OP_PACK);
    assign isQsub = issue.valid && (issue.op == PBS_OP_QSUB);
    assign isSaa = issue.valid && (issue.op == PBS_OP_SAA);
    assign isByteOp = isPack || isQsub || isSaa;

    // pair operands must name one of the two pairs
    assign pairOkA = (issue.srcA == PAIR_LOW_BASE) || (issue.srcA == PAIR_HIGH_BASE);
    assign pairOkB = (issue.srcB == PAIR_LOW_BASE) || (issue.srcB == PAIR_HIGH_BASE);

    // companions must be 16-bit and of an allowed class
    assign slotOkA = !slotA.valid || (!slotA.wide32 && slotA.allowed);
    assign slotOkB = !slotB.valid || (!slotB.wide32 && slotB.allowed);

    assign encodingOk = issue.wide32
        && slotOkA && slotOkB
        && (isPack || (pairOkA && pairOkB));
    assign accept = isByteOp && encodingOk;

    // parallel 32-bit loads do not raise misalignment while a byte op issues
    assign misalignSuppress = isByteOp && ((slotA.valid && slotA.load32 && slotA.misaligned)
        || (slotB.valid && slotB.load32 && slotB.misaligned));

    // pack gathers low byte of each half-word
    assign packWord = {regs[issue.srcB][23:16], regs[issue.srcB][7:0],
        regs[issue.srcA][23:16], regs[issue.srcA][7:0]};

    // byte windows from each pair
    pbs_byte_align u_alignA (
        .lowWord(regs[issue.srcA]),
        .highWord(regs[{issue.srcA[2:1], 1'b1}]),
        .reverse(issue.reverse),
        .offset(firstAlignIndex),
        .window(windowA)
    );

    pbs_byte_align u_alignB (
        .lowWord(regs[issue.srcB]),
        .highWord(regs[{issue.srcB[2:1], 1'b1}]),
        .reverse(issue.reverse),
        .offset(secondAlignIndex),
        .window(windowB)
    );

    // unsigned byte differences, sixteen-bit wrap gives sign extension
    genvar i;
    generate
        for (i = 0; i < LANES; i++) begin : g_diff
            assign diff[i] = {8'h00, windowA[i*BYTE_W +: BYTE_W]}
                - {8'h00, windowB[i*BYTE_W +: BYTE_W]};
        end
    endgenerate

    assign diffLow = {diff[1], diff[0]};
    assign diffHigh = {diff[3], diff[2]};

    // next write values
    always_comb begin
        writeA_d = '{en: 1'b0, addr: ADDR_RST, data: RESULT_RST};
        writeB_d = '{en: 1'b0, addr: ADDR_RST, data: RESULT_RST};
        if (accept && isPack) begin
            writeA_d = '{en: 1'b1, addr: issue.destA, data: packWord};
        end else if (accept && isQsub) begin
            writeA_d = '{en: 1'b1, addr: issue.destA, data: diffLow};
            writeB_d = '{en: 1'b1, addr: issue.destB, data: diffHigh};
        end
    end

    // result stage
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            writeA_q <= '{en: 1'b0, addr: ADDR_RST, data: RESULT_RST};
            writeB_q <= '{en: 1'b0, addr: ADDR_RST, data: RESULT_RST};
        end else begin
            writeA_q <= writeA_d;
            writeB_q <= writeB_d;
        end
    end

    // illegal encoding report
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            illegal_q <= 1'b0;
        end else begin
            illegal_q <= isByteOp && !encodingOk;
        end
    end

    // status flags are never written by these operations
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= 1'b0;
        end
    end

    // accumulate-unit operand hand-off
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            saaAccept_q <= 1'b0;
            saaA_q <= RESULT_RST;
            saaB_q <= RESULT_RST;
        end else begin
            saaAccept_q <= accept && isSaa;
            if (accept && isSaa) begin
                saaA_q <= windowA;
                saaB_q <= windowB;
            end
        end
    end

    assign writeA = writeA_q;
    assign writeB = writeB_q;
    assign illegalIssue = illegal_q;
    assign flagWrite = flag_q;
    assign saaAccept = saaAccept_q;
    assign saaBytesA = saaA_q;
    assign saaBytesB = saaB_q;

    // checks
    logic [DATA_W-1:0] expPack;
    logic [BYTE_W-1:0] expDiff0;
    logic [BYTE_W-1:0] expDiff2;
    assign expPack = {regs[issue.srcB][23:16], regs[issue.srcB][7:0],
        regs[issue.srcA][23:16], regs[issue.srcA][7:0]};
    assign expDiff0 = windowA[7:0] - windowB[7:0];
    assign expDiff2 = windowA[23:16] - windowB[23:16];

    sequence s_qsub_taken;
        issue.valid && issue.op == PBS_OP_QSUB && issue.wide32 && slotOkA && slotOkB
            && pairOkA && pairOkB;
    endsequence

    sequence s_both_written;
        writeA.en && writeB.en && !flagWrite;
    endsequence

    property p_pack_layout;
        @(posedge clock) disable iff (reset)
        (isPack && encodingOk) |=> (writeA.en && !writeB.en && writeA.data == $past(expPack));
    endproperty
    a_pack_layout: assert property (p_pack_layout) else $error("pack layout wrong");

    property p_qsub_lanes;
        @(posedge clock) disable iff (reset)
        s_qsub_taken |=> (writeA.data[7:0] == $past(expDiff0)
            && writeB.data[7:0] == $past(expDiff2)
            && writeA.addr == $past(issue.destA) && writeB.addr == $past(issue.destB));
    endproperty
    a_qsub_lanes: assert property (p_qsub_lanes) else $error("quad subtract lane wrong");

    property p_sign_extend;
        @(posedge clock) disable iff (reset)
        s_qsub_taken |=> (writeB.data[31:25] == {7{writeB.data[24]}}
            && writeA.data[15:9] == {7{writeA.data[8]}}
            && writeA.data[8] == ($past(windowA[7:0]) < $past(windowB[7:0])));
    endproperty
    a_sign_extend: assert property (p_sign_extend) else $error("difference not sign extended");

    property p_bad_pair;
        @(posedge clock) disable iff (reset)
        (isQsub && !(pairOkA && pairOkB)) |=> (illegalIssue && !writeA.en && !writeB.en);
    endproperty
    a_bad_pair: assert property (p_bad_pair) else $error("bad pair not refused");

    property p_first_offset;
        @(posedge clock) disable iff (reset)
        (isQsub && !issue.reverse && firstAlignIndex == 2'h0)
            |-> windowA == regs[issue.srcA];
    endproperty
    a_first_offset: assert property (p_first_offset) else $error("first offset wrong");

    property p_second_offset;
        @(posedge clock) disable iff (reset)
        (isQsub && !issue.reverse && secondAlignIndex == 2'h3)
            |-> windowB == {regs[issue.srcB | 3'h1][23:0], regs[issue.srcB][31:24]};
    endproperty
    a_second_offset: assert property (p_second_offset) else $error("second offset wrong");

    property p_reverse;
        @(posedge clock) disable iff (reset)
        (isQsub && issue.reverse && firstAlignIndex == 2'h2)
            |-> windowA == {regs[issue.srcA][15:0], regs[issue.srcA | 3'h1][31:16]};
    endproperty
    a_reverse: assert property (p_reverse) else $error("reverse window wrong");

    property p_suppress;
        @(posedge clock) disable iff (reset)
        (isByteOp && slotA.valid && slotA.load32 && slotA.misaligned) |-> misalignSuppress;
    endproperty
    a_suppress: assert property (p_suppress) else $error("misalign not suppressed");

    property p_narrow_word;
        @(posedge clock) disable iff (reset)
        (isByteOp && !issue.wide32) |=> (illegalIssue && !writeA.en && !saaAccept);
    endproperty
    a_narrow_word: assert property (p_narrow_word) else $error("16-bit encoding accepted");

    property p_bundle;
        @(posedge clock) disable iff (reset)
        (isByteOp && slotB.valid && slotB.wide32) |=> illegalIssue;
    endproperty
    a_bundle: assert property (p_bundle) else $error("bad companion accepted");

    property p_saa_pairs;
        @(posedge clock) disable iff (reset)
        saaAccept |-> $past(pairOkA && pairOkB && issue.wide32);
    endproperty
    a_saa_pairs: assert property (p_saa_pairs) else $error("accumulate took bad pair");

    property p_same_cycle;
        @(posedge clock) disable iff (reset)
        s_qsub_taken |=> s_both_written ##1 !flagWrite;
    endproperty
    a_same_cycle: assert property (p_same_cycle) else $error("destinations split or flags");

    property p_slot_refused;
        @(posedge clock) disable iff (reset)
        (isByteOp && slotB.valid && !slotB.allowed)
            |=> (illegalIssue && !writeA.en && !writeB.en);
    endproperty
    a_slot_refused: assert property (p_slot_refused) else $error("slot not refused");

    property p_saa_window;
        @(posedge clock) disable iff (reset)
        (isSaa && encodingOk && !issue.reverse && firstAlignIndex == 2'h1)
            |=> saaBytesA == {$past(regs[issue.srcA | 3'h1][7:0]),
                $past(regs[issue.srcA][31:8])};
    endproperty
    a_saa_window: assert property (p_saa_window) else $error("accumulate window wrong");
endmodule
`default_nettype wire

/* pbs_pkg.sv */
// Purpose: shared constants and types for the packed byte pack / quad subtract datapath
// Assumes: eight 32-bit data registers, one core clock
// Notes: no software-visible registers
`default_nettype none
package pbs_pkg;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int HALF_W = 16;
    localparam int REG_CNT = 8;
    localparam int LANES = 4;
    localparam int OFFSET_W = 2;
    localparam logic [2:0] PAIR_LOW_BASE = 3'h0;
    localparam logic [2:0] PAIR_HIGH_BASE = 3'h2;
    localparam logic [31:0] RESULT_RST = 32'h0;
    localparam logic [2:0] ADDR_RST = 3'h0;
    localparam int RESULT_LATENCY = 1;

    typedef enum logic [1:0] {
        PBS_OP_NONE,
        PBS_OP_PACK,
        PBS_OP_QSUB,
        PBS_OP_SAA
    } pbs_op_t;

    // srcA/srcB: any register for pack, low register of a pair otherwise
    typedef struct packed {
        logic valid;
        pbs_op_t op;
        logic wide32;
        logic reverse;
        logic [2:0] srcA;
        logic [2:0] srcB;
        logic [2:0] destA;
        logic [2:0] destB;
    } pbs_issue_t;

    // companion instruction in the same bundle
    typedef struct packed {
        logic valid;
        logic wide32;
        logic allowed;
        logic load32;
        logic misaligned;
    } pbs_slot_t;

    typedef struct packed {
        logic en;
        logic [2:0] addr;
        logic [31:0] data;
    } pbs_write_t;

    typedef logic [REG_CNT-1:0][DATA_W-1:0] pbs_regs_t;
endpackage
`default_nettype wire

/* pbs_byte_align.sv */
// Purpose: picks a four-byte window out of an eight-byte register pair view
// Assumes: offset already limited to two bits
// Notes: purely combinational
`default_nettype none
module pbs_byte_align (
    // pair data
    input wire logic [pbs_pkg::DATA_W-1:0] lowWord,
    input wire logic [pbs_pkg::DATA_W-1:0] highWord,
    // selection
    input wire logic reverse,
    input wire logic [pbs_pkg::OFFSET_W-1:0] offset,
    // window, lowest byte first
    output logic [pbs_pkg::DATA_W-1:0] window
);
    import pbs_pkg::*;

    logic [2*DATA_W-1:0] view;

    // reverse order puts the high register in bytes 3..0
    assign view = reverse ? {lowWord, highWord} : {highWord, lowWord};

    genvar i;
    generate
        for (i = 0; i < LANES; i++) begin : g_lane
            logic [2:0] pick;
            assign pick = 3'(offset) + 3'(i);
            assign window[i*BYTE_W +: BYTE_W] = view[pick*BYTE_W +: BYTE_W];
        end
    endgenerate
endmodule
`default_nettype wire

/* pbs_regfile_model.sv */
// Purpose: behavioural data register file facing the datapath
// Assumes: writes land on the edge after the write pulse
// Notes: bench may preload one register per cycle
`default_nettype none
module pbs_regfile_model (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // writes from datapath
    input wire pbs_pkg::pbs_write_t writeA,
    input wire pbs_pkg::pbs_write_t writeB,
    // preload from bench
    input wire logic loadEn,
    input wire logic [2:0] loadAddr,
    input wire logic [31:0] loadData,
    // register contents
    output pbs_pkg::pbs_regs_t regs
);
    import pbs_pkg::*;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            regs <= '0;
        end else begin
            if (loadEn) regs[loadAddr] <= loadData;
            if (writeA.en) regs[writeA.addr] <= writeA.data;
            if (writeB.en) regs[writeB.addr] <= writeB.data;
        end
    end
endmodule
`default_nettype wire

/* packed_byte_pack_subtract_tb.sv */
// Purpose: random and corner checks of pack, quad subtract and issue refusal
// Assumes: answers one cycle after the issue edge
// Notes: register file model reloaded at random
`default_nettype none
module packed_byte_pack_subtract_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pbs_pkg::*;
    logic clock, reset, loadEn, illegalIssue, flagWrite, misalignSuppress, saaAccept;
    logic [1:0] fIdx, sIdx;
    logic [2:0] loadAddr;
    logic [31:0] loadData, saaBytesA, saaBytesB;
    pbs_issue_t issue, is;
    pbs_slot_t slotA, slotB;
    pbs_regs_t regs;
    pbs_write_t writeA, writeB;
    int fail_count = 0;
    int samples_checked = 0;
    integer seed = 32'h66e2;

    pbs_datapath i_pbs_datapath (.clock(clock), .reset(reset), .issue(issue), .slotA(slotA),
        .slotB(slotB), .regs(regs), .firstAlignIndex(fIdx), .secondAlignIndex(sIdx),
        .writeA(writeA), .writeB(writeB), .illegalIssue(illegalIssue), .flagWrite(flagWrite),
        .misalignSuppress(misalignSuppress), .saaAccept(saaAccept), .saaBytesA(saaBytesA),
        .saaBytesB(saaBytesB));
    pbs_regfile_model i_pbs_regfile_model (.clock(clock), .reset(reset), .writeA(writeA),
        .writeB(writeB), .loadEn(loadEn), .loadAddr(loadAddr), .loadData(loadData), .regs(regs));

    always #5 clock = ~clock;

    function automatic logic [31:0] win(logic [31:0] lo, hi, logic rv, logic [1:0] off);
        logic [63:0] v;
        v = rv ? {lo, hi} : {hi, lo};
        return v[off*8 +: 32];
    endfunction

    function automatic logic [63:0] qsub(logic [31:0] a, b);
        logic [63:0] r;
        for (int k = 0; k < 4; k++) r[k*16 +: 16] = {8'h0, a[k*8 +: 8]} - {8'h0, b[k*8 +: 8]};
        return r;
    endfunction

    function automatic pbs_issue_t mk(pbs_op_t op, logic rv, logic [2:0] a, b, da, db);
        return '{1'b1, op, 1'b1, rv, a, b, da, db};
    endfunction

    function automatic pbs_slot_t okSlot();
        return '{1'($random(seed)), 1'b0, 1'b1, 1'($random(seed)), 1'($random(seed))};
    endfunction

    function automatic logic sbad(pbs_slot_t s);
        return s.valid && (s.wide32 || !s.allowed);
    endfunction

    task automatic cmpV(logic [35:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmpF(logic got, exp);
        cmpV({35'h0, got}, {35'h0, exp});
    endtask

    task automatic stop_test;
        $display("checks %0d failures %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic run(pbs_issue_t s, pbs_slot_t sa, sb);
        logic [31:0] wa, wb, pk;
        logic [63:0] q;
        logic bad;
        pbs_write_t ea, eb;
        @(posedge clock);
        issue <= s;
        slotA <= sa;
        slotB <= sb;
        fIdx <= 2'($random(seed));
        sIdx <= 2'($random(seed));
        loadAddr <= 3'($random(seed));
        loadData <= $random(seed);
        #1;
        wa = win(regs[s.srcA], regs[s.srcA | 3'h1], s.reverse, fIdx);
        wb = win(regs[s.srcB], regs[s.srcB | 3'h1], s.reverse, sIdx);
        q = qsub(wa, wb);
        pk = {regs[s.srcB][23:16], regs[s.srcB][7:0], regs[s.srcA][23:16], regs[s.srcA][7:0]};
        bad = !s.wide32 || sbad(sa) || sbad(sb) ||
            (s.op != PBS_OP_PACK && ((s.srcA | s.srcB) & 3'h5) != 3'h0);
        cmpF(misalignSuppress, (sa.valid && sa.load32 && sa.misaligned)
            || (sb.valid && sb.load32 && sb.misaligned));
        @(posedge clock);
        issue <= '0;
        #1;
        ea = '0;
        eb = '0;
        if (!bad && s.op == PBS_OP_PACK) ea = '{1'b1, s.destA, pk};
        if (!bad && s.op == PBS_OP_QSUB) ea = '{1'b1, s.destA, q[31:0]};
        if (!bad && s.op == PBS_OP_QSUB) eb = '{1'b1, s.destB, q[63:32]};
        cmpV(writeA, ea);
        cmpV(writeB, eb);
        cmpF(illegalIssue, bad);
        cmpF(saaAccept, !bad && s.op == PBS_OP_SAA);
        if (!bad && s.op == PBS_OP_SAA) cmpV({4'h0, saaBytesA}, {4'h0, wa});
        if (!bad && s.op == PBS_OP_SAA) cmpV({4'h0, saaBytesB}, {4'h0, wb});
        cmpF(flagWrite, 1'b0);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        stop_test;
    end

    initial begin
        clock = 0;
        reset = 1;
        issue = '0;
        slotA = '0;
        slotB = '0;
        fIdx = 0;
        sIdx = 0;
        loadEn = 0;
        loadAddr = 0;
        loadData = 0;
        repeat (12) @(posedge clock);
        reset <= 0;
        loadEn <= 1;
        for (int i = 0; i < 8; i++) run(mk(PBS_OP_PACK, 0, 3'(i), 3'(7 - i), 3'(i), 3'h0), '0, '0);
        for (int i = 0; i < 64; i++) run(mk(PBS_OP_QSUB, i[0], {i[1], 1'b0}, {i[2], 1'b0},
            3'($random(seed)), 3'($random(seed))), okSlot(), okSlot());
        @(posedge clock);
        issue <= mk(PBS_OP_QSUB, 0, 3'h0, 3'h2, 3'h1, 3'h3);
        @(posedge clock);
        reset <= 1;
        issue <= '0;
        #1;
        cmpV(writeA, 36'h0);
        cmpV(writeB, 36'h0);
        repeat (2) @(posedge clock);
        reset <= 0;
        for (int i = 0; i < 16; i++) run(mk(PBS_OP_SAA, i[0], {i[1], 1'b0}, {i[2], 1'b0},
            3'h0, 3'h0), okSlot(), okSlot());
        is = mk(PBS_OP_QSUB, 0, 3'h1, 3'h2, 3'h4, 3'h5);
        run(is, '0, '0);
        is.srcA = 3'h0;
        is.srcB = 3'h6;
        run(is, '0, '0);
        is.op = PBS_OP_SAA;
        is.srcB = 3'h3;
        run(is, '0, '0);
        is = mk(PBS_OP_PACK, 0, 3'h5, 3'h6, 3'h7, 3'h0);
        is.wide32 = 0;
        run(is, '0, '0);
        is.wide32 = 1;
        run(is, '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0}, '0);
        run(is, '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1}, '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
        stop_test;
    end
endmodule
`default_nettype wire
